//--- nes_host_top.sv
// Host controller that sequences program, erase, status, ID, reset and read-mode
// commands into a NAND device and exposes them as Avalon-MM registers.
// Assumes pin inputs synchronous to mclk_i; the ready line is pulled up outside.
`timescale 1ns/10ps
`default_nettype none
module nes_host_top #(
  parameter int BUSY_TIMEOUT_CYC = nes_pkg::BUSY_TIMEOUT_CYC,
  parameter logic [7:0] RESET_CMD = nes_pkg::CMD_RESET_DEF
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic io_oe_o,
  output logic cle_o,
  output logic ale_o,
  output logic chip_sel_n_o,
  output logic we_n_o,
  output logic read_strobe_n_o,
  output logic wp_n_o,
  input wire logic ready_busy_i
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_ISSUE = 5'b00010, ST_CYCLE = 5'b00100, ST_WB = 5'b01000, ST_RB = 5'b10000
  } nes_st_e;
  typedef struct packed {
    nes_st_e st;
    nes_pkg::nes_op_e op;
    logic [3:0] step;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic wp_en;
    logic ce_n;
    logic [7:0] sr;
    logic [7:0] maker;
    logic [7:0] part;
    logic timeout;
    logic loaded;
    logic [19:0] tmr;
    logic start;
    nes_pkg::nes_cyc_e cyc;
    logic [7:0] byte_out;
    nes_pkg::nes_dst_e dst;
    logic waitreq;
    logic [31:0] rdata;
  } nes_top_s;
  localparam nes_top_s RST_S = '{st: ST_IDLE, op: nes_pkg::OP_NONE, step: 4'h0, addr: 24'h00_0000,
    wdata: 8'h00, wp_en: 1'b0, ce_n: 1'b1, sr: 8'h00, maker: 8'h00, part: 8'h00, timeout: 1'b0,
    loaded: 1'b0, tmr: 20'h0_0000, start: 1'b0, cyc: nes_pkg::CYC_CMD, byte_out: 8'h00,
    dst: nes_pkg::DST_NONE, waitreq: 1'b1, rdata: 32'h0000_0000};
  localparam logic [19:0] TIMEOUT_LD = 20'(BUSY_TIMEOUT_CYC - 1);

  logic [1:0] rst_pipe_r;
  logic rst_n;
  nes_top_s s;
  nes_top_s n;
  nes_pkg::nes_step_s cur;
  logic eng_done;
  logic [7:0] eng_rdata;

  function automatic nes_pkg::nes_step_s mk(input logic wait_rb, input logic last,
    input nes_pkg::nes_cyc_e cyc, input nes_pkg::nes_dst_e dst, input logic [7:0] data);
    nes_pkg::nes_step_s r;
    r = '{wait_rb: wait_rb, last: last, cyc: cyc, dst: dst, data: data};
    return r;
  endfunction : mk

  function automatic nes_pkg::nes_step_s cmd(input logic [7:0] code);
    return mk(1'b0, 1'b0, nes_pkg::CYC_CMD, nes_pkg::DST_NONE, code);
  endfunction : cmd

  function automatic nes_pkg::nes_step_s adr(input logic [7:0] a);
    return mk(1'b0, 1'b0, nes_pkg::CYC_ADDR, nes_pkg::DST_NONE, a);
  endfunction : adr

  // Per-operation byte script; anything off the end is the closing step
  function automatic nes_pkg::nes_step_s step_of(input nes_pkg::nes_op_e op, input logic [3:0] idx,
    input logic [23:0] a, input logic [7:0] wd, input logic [7:0] rc);
    nes_pkg::nes_step_s r;
    nes_pkg::nes_step_s fin;
    nes_pkg::nes_step_s rb;
    nes_pkg::nes_step_s rd_sr;
    fin = mk(1'b0, 1'b1, nes_pkg::CYC_CMD, nes_pkg::DST_NONE, 8'h00);
    rb = mk(1'b1, 1'b0, nes_pkg::CYC_CMD, nes_pkg::DST_NONE, 8'h00);
    rd_sr = mk(1'b0, 1'b0, nes_pkg::CYC_READ, nes_pkg::DST_SR, 8'h00);
    r = fin;
    case (op)
      nes_pkg::OP_PROGRAM:
        case (idx)
          4'h0: r = cmd(nes_pkg::CMD_PROG_LOAD);
          4'h1: r = adr(a[7:0]);
          4'h2: r = adr(a[16:9]);
          4'h3: r = adr({2'b00, a[22:17]});
          4'h4: r = mk(1'b0, 1'b0, nes_pkg::CYC_WDATA, nes_pkg::DST_NONE, wd);
          4'h5: r = cmd(nes_pkg::CMD_PROG_GO);
          4'h6: r = rb;
          4'h7: r = cmd(nes_pkg::CMD_STATUS);
          4'h8: r = rd_sr;
          default: r = fin;
        endcase
      nes_pkg::OP_ERASE:
        case (idx)
          4'h0: r = cmd(nes_pkg::CMD_ERASE_SETUP);
          4'h1: r = adr({a[16:13], 4'h0});
          4'h2: r = adr({2'b00, a[22:17]});
          4'h3: r = cmd(nes_pkg::CMD_ERASE_GO);
          4'h4: r = rb;
          4'h5: r = cmd(nes_pkg::CMD_STATUS);
          4'h6: r = rd_sr;
          default: r = fin;
        endcase
      nes_pkg::OP_STATUS:
        case (idx)
          4'h0: r = cmd(nes_pkg::CMD_STATUS);
          4'h1: r = rd_sr;
          default: r = fin;
        endcase
      nes_pkg::OP_ID:
        case (idx)
          4'h0: r = cmd(nes_pkg::CMD_ID);
          4'h1: r = adr(nes_pkg::ID_ADDR);
          4'h2: r = mk(1'b0, 1'b0, nes_pkg::CYC_READ, nes_pkg::DST_MAKER, 8'h00);
          4'h3: r = mk(1'b0, 1'b0, nes_pkg::CYC_READ, nes_pkg::DST_PART, 8'h00);
          default: r = fin;
        endcase
      nes_pkg::OP_RESET:
        case (idx)
          4'h0: r = cmd(rc);
          4'h1: r = rb;
          default: r = fin;
        endcase
      nes_pkg::OP_READ_MODE:
        // Status and ID modes persist, so page reads need the read command again
        if (idx == 4'h0)
          r = cmd(nes_pkg::CMD_READ_MAIN);
      default:
        r = fin;
    endcase
    return r;
  endfunction : step_of

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_pipe_r <= 2'b00;
    else
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end
  assign rst_n = rst_pipe_r[1];

  assign cur = step_of(s.op, s.step, s.addr, s.wdata, RESET_CMD);

  always_comb
  begin
    n = s;
    n.start = 1'b0;
    n.waitreq = 1'b1;
    if ((avs_read_i || avs_write_i) && s.waitreq)
    begin
      n.waitreq = 1'b0;
      n.rdata = 32'h0000_0000;
      unique case (avs_address_i)
        nes_pkg::REG_CTRL: n.rdata = {23'h00_0000, s.wp_en, 5'h00, s.op};
        nes_pkg::REG_ADDR: n.rdata = {8'h00, s.addr};
        nes_pkg::REG_WDATA: n.rdata = {24'h00_0000, s.wdata};
        nes_pkg::REG_STAT:
        begin
          n.rdata[nes_pkg::STAT_BUSY_BIT] = (s.st != ST_IDLE);
          n.rdata[nes_pkg::STAT_RB_BIT] = ready_busy_i;
          n.rdata[nes_pkg::STAT_TIMEOUT_BIT] = s.timeout;
          // Fail bit is taken as the device reports it: only unprogrammed ones count
          n.rdata[nes_pkg::STAT_FAIL_BIT] = s.sr[nes_pkg::SR_FAIL_BIT];
          n.rdata[nes_pkg::STAT_READY_BIT] = s.sr[nes_pkg::SR_READY_BIT];
          n.rdata[nes_pkg::STAT_SR_LSB +: 8] = s.sr;
          n.rdata[nes_pkg::STAT_MAKER_LSB +: 8] = s.maker;
          n.rdata[nes_pkg::STAT_PART_LSB +: 8] = s.part;
        end
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_i && !s.waitreq)
    begin
      unique case (avs_address_i)
        nes_pkg::REG_CTRL:
        begin
          n.wp_en = avs_writedata_i[nes_pkg::CTRL_WP_EN_BIT];
          // A new operation is only taken while idle; others are dropped
          if (s.st == ST_IDLE && avs_writedata_i[2:0] != 3'h0)
          begin
            n.op = nes_pkg::nes_op_e'(avs_writedata_i[2:0]);
            n.step = 4'h0;
            n.ce_n = 1'b0;
            n.loaded = 1'b0;
            n.timeout = 1'b0;
            n.st = ST_ISSUE;
          end
        end
        nes_pkg::REG_ADDR: n.addr = avs_writedata_i[23:0];
        nes_pkg::REG_WDATA: n.wdata = avs_writedata_i[7:0];
        default: n.addr = s.addr;
      endcase
    end
    unique case (s.st)
      ST_IDLE:
        n.ce_n = n.ce_n;
      ST_ISSUE:
        if (cur.last)
        begin
          n.st = ST_IDLE;
          n.ce_n = 1'b1;
        end
        else if (cur.wait_rb)
        begin
          n.tmr = nes_pkg::WB_LD;
          n.st = ST_WB;
        end
        else
        begin
          n.start = 1'b1;
          n.cyc = cur.cyc;
          n.byte_out = cur.data;
          n.dst = cur.dst;
          n.loaded = s.loaded || (cur.cyc == nes_pkg::CYC_WDATA);
          n.st = ST_CYCLE;
        end
      ST_CYCLE:
        if (eng_done)
        begin
          unique case (s.dst)
            nes_pkg::DST_SR: n.sr = eng_rdata;
            nes_pkg::DST_MAKER: n.maker = eng_rdata;
            nes_pkg::DST_PART: n.part = eng_rdata;
            nes_pkg::DST_NONE: n.sr = s.sr;
          endcase
          n.step = s.step + 4'h1;
          n.st = ST_ISSUE;
        end
      ST_WB:
        // The device may take a while to pull the line low after the strobe
        if (s.tmr == 20'h0_0000)
        begin
          n.tmr = TIMEOUT_LD;
          n.st = ST_RB;
        end
        else
          n.tmr = s.tmr - 20'h0_0001;
      ST_RB:
        if (ready_busy_i || s.tmr == 20'h0_0000)
        begin
          n.timeout = !ready_busy_i;
          n.step = s.step + 4'h1;
          n.st = ST_ISSUE;
        end
        else
          n.tmr = s.tmr - 20'h0_0001;
      default:
        n = RST_S;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      s <= RST_S;
    else
      s <= n;
  end

  nes_pin_cycle u_cycle (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .start_i(s.start),
    .kind_i(s.cyc),
    .byte_i(s.byte_out),
    .io_i(io_i),
    .io_o(io_o),
    .io_oe_o(io_oe_o),
    .cle_o(cle_o),
    .ale_o(ale_o),
    .we_n_o(we_n_o),
    .re_n_o(read_strobe_n_o),
    .done_o(eng_done),
    .rdata_o(eng_rdata)
  );

  assign avs_readdata_o = s.rdata;
  assign avs_waitrequest_o = s.waitreq;
  assign chip_sel_n_o = s.ce_n;
  assign wp_n_o = s.wp_en;

  no_cmd_busy_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (s.st == ST_WB || s.st == ST_RB) |-> (we_n_o && !cle_o && !ale_o))
    else $error("pin cycle while waiting on busy");
  erase_addr_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (s.start && s.op == nes_pkg::OP_ERASE && s.cyc == nes_pkg::CYC_ADDR && s.step == 4'h1)
    |-> (s.byte_out[3:0] == 4'h0)) else $error("erase address carries page bits");
  prog_confirm_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (s.start && s.cyc == nes_pkg::CYC_CMD && s.byte_out == nes_pkg::CMD_PROG_GO) |-> s.loaded)
    else $error("program confirm without data");
  erase_order_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (s.start && s.cyc == nes_pkg::CYC_CMD && s.byte_out == nes_pkg::CMD_ERASE_GO)
    |-> (s.op == nes_pkg::OP_ERASE && s.step == 4'h3)) else $error("erase confirm out of order");
  rb_release_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (s.st == ST_RB && ready_busy_i) |=> (s.st == ST_ISSUE && !s.timeout)) else $error("ready not followed");
  wp_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(wp_n_o) |-> $past(avs_write_i && !avs_waitrequest_o && avs_address_i == nes_pkg::REG_CTRL
    && avs_writedata_i[nes_pkg::CTRL_WP_EN_BIT])) else $error("write protect released early");
  sr_capture_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (eng_done && s.st == ST_CYCLE && s.dst == nes_pkg::DST_SR) |=> (s.sr == $past(eng_rdata)))
    else $error("status byte not captured");
  read_select_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !read_strobe_n_o |-> (!chip_sel_n_o && !io_oe_o)) else $error("read strobe without select");
  reset_code_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (s.start && s.op == nes_pkg::OP_RESET && s.step == 4'h0)
    |-> (s.byte_out == RESET_CMD) ##2 (!we_n_o && cle_o && io_o == RESET_CMD))
    else $error("reset code wrong");
  id_order_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (s.start && s.op == nes_pkg::OP_ID && s.cyc == nes_pkg::CYC_READ) |-> (s.step inside {4'h2, 4'h3}))
    else $error("id read out of order");

  prog_done_c: cover property (@(posedge mclk_i) disable iff (!rst_n)
    (s.op == nes_pkg::OP_PROGRAM && s.st == ST_ISSUE && cur.last));
  erase_done_c: cover property (@(posedge mclk_i) disable iff (!rst_n)
    (s.op == nes_pkg::OP_ERASE && s.st == ST_ISSUE && cur.last));
  id_done_c: cover property (@(posedge mclk_i) disable iff (!rst_n)
    (s.op == nes_pkg::OP_ID && s.st == ST_ISSUE && cur.last));
endmodule : nes_host_top
`default_nettype wire

//--- nes_pkg.sv
// Constants, enumerations and the step record shared by the NAND sequencing host.
// Assumes a 25 MHz single clock; all pin timings are rounded to whole cycles of it.
package nes_pkg;
  localparam int CLK_NS = 40;
  localparam int SETUP_NS = 20;
  localparam int WE_LOW_NS = 25;
  localparam int RE_LOW_NS = 50;
  localparam int HOLD_NS = 10;
  localparam int WB_NS = 100;
  localparam int BUSY_TIMEOUT_NS = 10_000_000;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RE_CYC = (RE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC = (WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_TIMEOUT_CYC = BUSY_TIMEOUT_NS / CLK_NS;
  localparam logic [2:0] SETUP_LD = 3'(SETUP_CYC - 1);
  localparam logic [2:0] WE_LD = 3'(WE_CYC - 1);
  localparam logic [2:0] RE_LD = 3'(RE_CYC - 1);
  localparam logic [2:0] HOLD_LD = 3'(HOLD_CYC - 1);
  localparam logic [19:0] WB_LD = 20'(WB_CYC - 1);

  localparam logic [7:0] CMD_PROG_LOAD = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_READ_MAIN = 8'h00;
  localparam logic [7:0] ID_ADDR = 8'h00;
  localparam logic [7:0] CMD_RESET_DEF = 8'hff;

  localparam int SR_FAIL_BIT = 0;
  localparam int SR_READY_BIT = 6;
  localparam int SR_UNPROT_BIT = 7;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  localparam int CTRL_WP_EN_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RB_BIT = 1;
  localparam int STAT_TIMEOUT_BIT = 2;
  localparam int STAT_FAIL_BIT = 3;
  localparam int STAT_READY_BIT = 4;
  localparam int STAT_SR_LSB = 8;
  localparam int STAT_MAKER_LSB = 16;
  localparam int STAT_PART_LSB = 24;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_PROGRAM = 3'h1, OP_ERASE = 3'h2, OP_STATUS = 3'h3,
    OP_ID = 3'h4, OP_RESET = 3'h5, OP_READ_MODE = 3'h6
  } nes_op_e;
  typedef enum logic [1:0] {CYC_CMD = 2'h0, CYC_ADDR = 2'h1, CYC_WDATA = 2'h2, CYC_READ = 2'h3} nes_cyc_e;
  typedef enum logic [1:0] {DST_NONE = 2'h0, DST_SR = 2'h1, DST_MAKER = 2'h2, DST_PART = 2'h3} nes_dst_e;
  typedef struct packed {
    logic wait_rb;
    logic last;
    nes_cyc_e cyc;
    nes_dst_e dst;
    logic [7:0] data;
  } nes_step_s;
endpackage : nes_pkg

//--- nes_pin_cycle.sv
// One command, address, data-in or read cycle on the multiplexed byte port.
// Assumes chip select is already low and io_i is synchronous to mclk_i.
`timescale 1ns/10ps
`default_nettype none
module nes_pin_cycle (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire nes_pkg::nes_cyc_e kind_i,
  input wire logic [7:0] byte_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic io_oe_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic re_n_o,
  output logic done_o,
  output logic [7:0] rdata_o
);
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001, PH_SETUP = 4'b0010, PH_STROBE = 4'b0100, PH_HOLD = 4'b1000
  } nes_ph_e;
  typedef struct packed {
    nes_ph_e ph;
    logic [2:0] cnt;
    nes_pkg::nes_cyc_e kind;
    logic [7:0] io;
    logic oe;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic done;
    logic [7:0] rdata;
  } nes_pc_s;
  localparam nes_pc_s RST_S = '{ph: PH_IDLE, cnt: 3'h0, kind: nes_pkg::CYC_CMD, io: 8'h00, oe: 1'b0,
                                 cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, done: 1'b0, rdata: 8'h00};
  nes_pc_s s;
  nes_pc_s n;

  always_comb
  begin
    n = s;
    n.done = 1'b0;
    unique case (s.ph)
      PH_IDLE:
        if (start_i)
        begin
          n.ph = PH_SETUP;
          n.cnt = nes_pkg::SETUP_LD;
          n.kind = kind_i;
          n.cle = (kind_i == nes_pkg::CYC_CMD);
          n.ale = (kind_i == nes_pkg::CYC_ADDR);
          n.io = byte_i;
          n.oe = (kind_i != nes_pkg::CYC_READ);
        end
      PH_SETUP:
        if (s.cnt == 3'h0)
        begin
          n.ph = PH_STROBE;
          // Read strobe low long enough to cover the device's output access time
          if (s.kind == nes_pkg::CYC_READ)
          begin
            n.cnt = nes_pkg::RE_LD;
            n.re_n = 1'b0;
          end
          else
          begin
            n.cnt = nes_pkg::WE_LD;
            n.we_n = 1'b0;
          end
        end
        else
          n.cnt = s.cnt - 3'h1;
      PH_STROBE:
        if (s.cnt == 3'h0)
        begin
          n.ph = PH_HOLD;
          n.cnt = nes_pkg::HOLD_LD;
          n.we_n = 1'b1;
          n.re_n = 1'b1;
          if (s.kind == nes_pkg::CYC_READ)
            n.rdata = io_i;
        end
        else
          n.cnt = s.cnt - 3'h1;
      PH_HOLD:
        if (s.cnt == 3'h0)
        begin
          n.ph = PH_IDLE;
          n.cle = 1'b0;
          n.ale = 1'b0;
          n.oe = 1'b0;
          n.done = 1'b1;
        end
        else
          n.cnt = s.cnt - 3'h1;
      default:
        n = RST_S;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= RST_S;
    else
      s <= n;
  end

  assign io_o = s.io;
  assign io_oe_o = s.oe;
  assign cle_o = s.cle;
  assign ale_o = s.ale;
  assign we_n_o = s.we_n;
  assign re_n_o = s.re_n;
  assign done_o = s.done;
  assign rdata_o = s.rdata;
endmodule : nes_pin_cycle
`default_nettype wire

//--- nes_dev_model.sv
// Behavioural model of the flash device seen by the sequencing host.
// Assumes the bench resolves the byte bus and pulls the ready line up.
`timescale 1ns/10ps
`default_nettype none
module nes_dev_model #(
  parameter logic [7:0] RESET_CMD = 8'hff,
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'hc3 // Arbitrary value
) (
  input wire logic mclk_i,
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] io_i,
  input wire logic [15:0] busy_len_i,
  input wire logic [7:0] stuck_i,
  output logic [7:0] io_o,
  output logic io_oe_o,
  output logic rb_low_o
);
  logic [7:0] cmd_r = 8'h00;
  logic [7:0] adr_r [0:2];
  logic [7:0] data_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic [9:0] blk_r = 10'h000;
  logic loaded_r = 1'h0;
  logic fail_r = 1'h0;
  logic busy, ers_ok;
  logic [7:0] status, val;
  int acnt_r = 0;
  int busy_cnt = 0;
  int id_idx = 0;
  assign busy = busy_cnt != 0;
  assign ers_ok = (cmd_r == 8'h60) && (acnt_r == 2);
  assign status = {wp_n_i, ~busy, 5'h00, fail_r};
  assign rb_low_o = busy;
  assign val = (cmd_r == 8'h70) ? status : (cmd_r == 8'h90) ? ((id_idx == 0) ? MAKER_ID : PART_ID) : data_r;
  assign io_oe_o = !ce_n_i && !re_n_i;
  // Released bus shows the inverse of the last byte so stale data never reads as valid
  assign io_o = io_oe_o ? val : ~last_r;
  always @(posedge mclk_i)
    if (busy_cnt > 0)
      busy_cnt = busy_cnt - 1;
  always @(posedge re_n_i)
    if (!ce_n_i)
    begin
      last_r = val;
      id_idx = id_idx + 1;
    end
  always @(posedge we_n_i)
  begin
    if (!ce_n_i && cle_i && (!busy || io_i == 8'h70 || io_i == RESET_CMD))
    begin
      if (io_i == RESET_CMD)
        busy_cnt = 0;
      if (io_i == 8'h80)
        loaded_r = 1'h0;
      if (io_i == 8'h10 && loaded_r)
      begin
        fail_r = |(~data_r & stuck_i);
        busy_cnt = busy_len_i;
        loaded_r = 1'h0;
      end
      if (io_i == 8'hd0 && ers_ok)
      begin
        blk_r = {adr_r[1][5:0], adr_r[0][7:4]};
        fail_r = 1'h0;
        busy_cnt = busy_len_i;
      end
      cmd_r = io_i;
      acnt_r = 0;
      id_idx = 0;
    end
    else if (!ce_n_i && ale_i && !busy)
    begin
      if (acnt_r < 3)
        adr_r[acnt_r] = io_i;
      acnt_r = acnt_r + 1;
    end
    else if (!ce_n_i && !cle_i && !busy && cmd_r == 8'h80)
    begin
      data_r = io_i;
      loaded_r = 1'h1;
    end
  end
endmodule : nes_dev_model
`default_nettype wire

//--- nes_host_top_tb_top.sv
// Self-checking bench for the sequencing host against the device model.
// Assumes the host's Avalon answer within 20 cycles and its busy flag in STAT.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      bad_count++; \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
  end
module nes_host_top_tb_top;
  logic mclk, reset_n, avs_read, avs_write, cle, ale, ce_n, we_n, re_n, wp_n, io_h_oe, io_d_oe, rb_low, avs_wr;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] io_h, io_d, stuck, wd;
  logic [15:0] busy_len;
  logic [23:0] a;
  int compares, bad_count;
  nes_host_top #(.BUSY_TIMEOUT_CYC(200), .RESET_CMD(8'hff)) dut_u (.mclk_i(mclk), .reset_n_i(reset_n),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_wr), .io_i(io_h_oe ? io_h : io_d), .io_o(io_h),
    .io_oe_o(io_h_oe), .cle_o(cle), .ale_o(ale), .chip_sel_n_o(ce_n), .we_n_o(we_n), .read_strobe_n_o(re_n),
    .wp_n_o(wp_n), .ready_busy_i(~rb_low));
  nes_dev_model #(.RESET_CMD(8'hff)) part_u (.mclk_i(mclk), .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
    .re_n_i(re_n), .wp_n_i(wp_n), .io_i(io_h), .busy_len_i(busy_len), .stuck_i(stuck), .io_o(io_d),
    .io_oe_o(io_d_oe), .rb_low_o(rb_low));
  function automatic logic [7:0] exp_sr(input logic fl, input logic rdy, input logic wpn);
    return {wpn, rdy, 5'h00, fl};
  endfunction : exp_sr
  function automatic logic exp_fail(input logic [7:0] d, input logic [7:0] sk);
    return |(~d & sk);
  endfunction : exp_fail
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic av(input logic wr, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] rq);
    int n;
    n = 0;
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_wr !== 1'h0 && n < 20);
    rq = avs_readdata;
    if (avs_wr !== 1'h0)
    begin
      bad_count++;
      summarize();
    end
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge mclk);
  endtask : av
  task automatic run_op(input logic [2:0] op, input logic wp_rel, output logic [31:0] st);
    int n;
    n = 0;
    av(1'h1, nes_pkg::REG_CTRL, {23'h00_0000, wp_rel, 5'h00, op}, st);
    do
    begin
      av(1'h0, nes_pkg::REG_STAT, 32'h0000_0000, st);
      n++;
    end
    while (st[nes_pkg::STAT_BUSY_BIT] !== 1'h0 && n < 3000);
    if (st[nes_pkg::STAT_BUSY_BIT] !== 1'h0)
    begin
      bad_count++;
      summarize();
    end
  endtask : run_op
  // Host and device must never drive the byte bus together
  always @(posedge mclk)
    if (io_h_oe === 1'h1 && io_d_oe === 1'h1)
      `CHK("bus contention", 1'h0, 1'h1);
  initial
  begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    reset_n = 1'h0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    busy_len = 16'h0020;
    stuck = 8'h00;
    void'($urandom(32'h36ff_196e));
    repeat (8) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (4) @(posedge mclk);
    av(1'h0, 4'h2, 32'h0000_0000, q);
    `CHK("unmapped read", 32'h0000_0000, q);
    run_op(3'h3, 1'h0, q);
    `CHK("protect pin", 1'h0, wp_n);
    `CHK("status protected", exp_sr(1'h0, 1'h1, 1'h0), q[15:8]);
    $display("test status done");
    for (int i = 0; i < 6; i++)
    begin
      a = 24'($urandom) & 24'h7f_ffff;
      wd = 8'($urandom);
      stuck <= (i == 0) ? 8'h00 : 8'($urandom);
      busy_len <= 16'(20 + $urandom % 100);
      av(1'h1, nes_pkg::REG_ADDR, {8'h00, a}, q);
      av(1'h1, nes_pkg::REG_WDATA, {24'h00_0000, wd}, q);
      run_op((i < 4) ? 3'h1 : 3'h2, 1'h1, q);
      if (i < 4)
      begin
        `CHK("program status", exp_sr(exp_fail(wd, stuck), 1'h1, 1'h1), q[15:8]);
        `CHK("fail flag", exp_fail(wd, stuck), q[nes_pkg::STAT_FAIL_BIT]);
        `CHK("loaded byte", wd, part_u.data_r);
      end
      else
      begin
        `CHK("erase block", a[22:13], part_u.blk_r);
        `CHK("erase status", exp_sr(1'h0, 1'h1, 1'h1), q[15:8]);
      end
      `CHK("ready bit", 1'h1, q[nes_pkg::STAT_READY_BIT]);
      `CHK("ready line", 1'h1, q[nes_pkg::STAT_RB_BIT]);
    end
    $display("test program and erase done");
    run_op(3'h4, 1'h1, q);
    `CHK("maker byte", part_u.MAKER_ID, q[23:16]);
    `CHK("part byte", part_u.PART_ID, q[31:24]);
    $display("test id done");
    // Device stays busy past the host's wait limit, then reset aborts it
    busy_len <= 16'd1000;
    run_op(3'h2, 1'h1, q);
    `CHK("timeout flag", 1'h1, q[nes_pkg::STAT_TIMEOUT_BIT]);
    `CHK("busy status", exp_sr(1'h0, 1'h0, 1'h1), q[15:8]);
    run_op(3'h5, 1'h1, q);
    `CHK("line after reset", 1'h1, q[nes_pkg::STAT_RB_BIT]);
    run_op(3'h3, 1'h1, q);
    `CHK("status after reset", exp_sr(1'h0, 1'h1, 1'h1), q[15:8]);
    $display("test timeout and reset done");
    run_op(3'h6, 1'h1, q);
    `CHK("read mode", 8'h00, part_u.cmd_r);
    av(1'h0, nes_pkg::REG_CTRL, 32'h0000_0000, q);
    `CHK("control readback", 9'h106, q[8:0]);
    $display("test read mode done");
    summarize();
  end
endmodule : nes_host_top_tb_top
`default_nettype wire
